// ==== hdl/maabe_regs.svh ====
// named constants for the bit, branch and add execution unit
// assumes inclusion by bare name from the alu and exec design files of the unit
`ifndef MAABE_REGS_SVH
`define MAABE_REGS_SVH

`define MAABE_DATA_W     8
`define MAABE_FADDR_W    7
`define MAABE_BSEL_W     3
`define MAABE_OFS_W      9
`define MAABE_PC_W       15
`define MAABE_NIB_W      4
`define MAABE_MSB        7
`define MAABE_LSB        0
`define MAABE_DEST_ACC   1'b0
`define MAABE_DEST_FILE  1'b1
`define MAABE_BIT_ONE    8'h01
`define MAABE_BYTE_ZERO  8'h00

`endif

// ==== hdl/maabe_pkg.sv ====
// types shared by the execution unit and its arithmetic core
// assumes maabe_regs.svh is compiled alongside
package maabe_pkg;
   typedef enum logic [2:0] {
      op_none                 = 3'h0,
      add_acc_to_file         = 3'h1,
      add_acc_file_with_carry = 3'h2,
      arith_shift_right       = 3'h3,
      clear_bit_op            = 3'h4,
      skip_if_bit_clear       = 3'h5,
      relative_jump           = 3'h6
   } maabe_op_t;

   typedef enum logic [1:0] {
      st_run = 2'b01,
      st_nop = 2'b10
   } maabe_state_t;
endpackage : maabe_pkg

// ==== hdl/maabe_alu.sv ====
// combinational arithmetic and bit core of the execution unit
// assumes operands are stable for the whole accepting cycle
`include "maabe_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module maabe_alu (
   input  wire logic [2:0]                  op_code,
   input  wire logic [`MAABE_DATA_W-1:0]    acc_data,
   input  wire logic [`MAABE_DATA_W-1:0]    file_data,
   input  wire logic                        carry_in,
   input  wire logic [`MAABE_BSEL_W-1:0]    bit_sel,
   output var  logic [`MAABE_DATA_W-1:0]    result,
   output var  logic                        carry_out,
   output var  logic                        half_carry_out,
   output var  logic                        zero_out,
   output var  logic                        bit_val
);
   import maabe_pkg::*;

   logic [`MAABE_DATA_W:0] sum;
   logic [`MAABE_NIB_W:0]  nib;
   logic                   cin_eff;

   always_comb begin
      cin_eff = (op_code == add_acc_file_with_carry) ? carry_in : 1'b0;
      sum     = {1'b0, acc_data} + {1'b0, file_data} + {{`MAABE_DATA_W{1'b0}}, cin_eff};
      nib     = {1'b0, acc_data[`MAABE_NIB_W-1:0]} + {1'b0, file_data[`MAABE_NIB_W-1:0]}
                + {{`MAABE_NIB_W{1'b0}}, cin_eff};
      bit_val = file_data[bit_sel];
      result         = file_data;
      carry_out      = carry_in;
      half_carry_out = 1'b0;
      case (op_code)
         add_acc_to_file, add_acc_file_with_carry: begin
            result         = sum[`MAABE_DATA_W-1:0];
            carry_out      = sum[`MAABE_DATA_W];
            half_carry_out = nib[`MAABE_NIB_W];
         end
         arith_shift_right: begin
            result    = {file_data[`MAABE_MSB], file_data[`MAABE_MSB:1]};
            carry_out = file_data[`MAABE_LSB];
         end
         clear_bit_op: begin
            result = file_data & ~(`MAABE_BIT_ONE << bit_sel);
         end
         default: begin
            result = file_data;
         end
      endcase
      zero_out = (result == `MAABE_BYTE_ZERO);
   end
endmodule : maabe_alu
`default_nettype wire

// ==== hdl/maabe_exec.sv ====
// execution unit for add, add with carry, arithmetic shift, bit clear, skip and relative jump
// assumes decoder presents one op per accepted cycle with file data already read, same clock
`include "maabe_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module maabe_exec #(
   parameter int PC_W = `MAABE_PC_W
) (
   input  wire logic                        clock,
   input  wire logic                        rst,
   input  wire logic                        op_valid,
   input  wire maabe_pkg::maabe_op_t        op_code,
   input  wire logic                        dest_sel,
   input  wire logic [`MAABE_FADDR_W-1:0]   file_addr,
   input  wire logic [`MAABE_BSEL_W-1:0]    bit_sel,
   input  wire logic [`MAABE_OFS_W-1:0]     jump_offset,
   input  wire logic [`MAABE_DATA_W-1:0]    file_rdata,
   input  wire logic [`MAABE_DATA_W-1:0]    acc_data,
   input  wire logic [PC_W-1:0]             pc_current,
   output var  logic                        op_ready,
   output var  logic                        acc_we,
   output var  logic [`MAABE_DATA_W-1:0]    acc_wdata,
   output var  logic                        file_we,
   output var  logic [`MAABE_FADDR_W-1:0]   file_waddr,
   output var  logic [`MAABE_DATA_W-1:0]    file_wdata,
   output var  logic                        carry_flag,
   output var  logic                        half_carry_flag,
   output var  logic                        zero_flag,
   output var  logic                        pc_load,
   output var  logic [PC_W-1:0]             pc_target,
   output var  logic                        squash_next
);
   import maabe_pkg::*;

   initial begin
      if (PC_W <= `MAABE_OFS_W) begin
         $error("program counter must be wider than the jump offset");
      end
   end

   maabe_state_t              state;
   logic                      accept;
   logic                      is_arith;
   logic                      do_skip;
   logic                      two_cycle;
   logic [`MAABE_DATA_W-1:0]  alu_result;
   logic                      alu_c;
   logic                      alu_dc;
   logic                      alu_z;
   logic                      alu_bit;
   logic [PC_W-1:0]           ofs_ext;
   logic [PC_W-1:0]           next_pc_target;

   maabe_alu u_alu (
      .op_code        (op_code),
      .acc_data       (acc_data),
      .file_data      (file_rdata),
      .carry_in       (carry_flag),
      .bit_sel        (bit_sel),
      .result         (alu_result),
      .carry_out      (alu_c),
      .half_carry_out (alu_dc),
      .zero_out       (alu_z),
      .bit_val        (alu_bit)
   );

   always_comb begin
      accept    = op_valid && (state == st_run);
      is_arith  = (op_code == add_acc_to_file) || (op_code == add_acc_file_with_carry)
                  || (op_code == arith_shift_right);
      do_skip   = (op_code == skip_if_bit_clear) && !alu_bit;
      two_cycle = do_skip || (op_code == relative_jump);
      ofs_ext   = {{(PC_W-`MAABE_OFS_W){jump_offset[`MAABE_OFS_W-1]}}, jump_offset};
      // pc_current is the address of the jump itself, so add the fetch increment here
      next_pc_target = pc_current + {{(PC_W-1){1'b0}}, 1'b1} + ofs_ext;
   end

   // sequencing: the second cycle of a two-cycle op accepts nothing
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state    <= st_run;
         op_ready <= 1'b1;
      end else begin
         case (state)
            st_run: begin
               if (accept && two_cycle) begin
                  state    <= st_nop;
                  op_ready <= 1'b0;
               end
            end
            st_nop: begin
               state    <= st_run;
               op_ready <= 1'b1;
            end
            default: begin
               state    <= st_run;
               op_ready <= 1'b1;
            end
         endcase
      end
   end

   // result writeback, strobes last one cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         acc_we     <= 1'b0;
         acc_wdata  <= `MAABE_BYTE_ZERO;
         file_we    <= 1'b0;
         file_waddr <= {`MAABE_FADDR_W{1'b0}};
         file_wdata <= `MAABE_BYTE_ZERO;
      end else begin
         acc_we  <= 1'b0;
         file_we <= 1'b0;
         if (accept && is_arith) begin
            acc_we  <= (dest_sel == `MAABE_DEST_ACC);
            file_we <= (dest_sel == `MAABE_DEST_FILE);
         end
         if (accept && (op_code == clear_bit_op)) begin
            file_we <= 1'b1;
         end
         if (accept) begin
            acc_wdata  <= alu_result;
            file_waddr <= file_addr;
            file_wdata <= alu_result;
         end
      end
   end

   // status flags; bit ops and jumps leave them alone
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         carry_flag      <= 1'b0;
         half_carry_flag <= 1'b0;
         zero_flag       <= 1'b0;
      end else if (accept) begin
         case (op_code)
            add_acc_to_file, add_acc_file_with_carry: begin
               carry_flag      <= alu_c;
               half_carry_flag <= alu_dc;
               zero_flag       <= alu_z;
            end
            arith_shift_right: begin
               carry_flag <= alu_c;
               zero_flag  <= alu_z;
            end
            default: begin
               carry_flag <= carry_flag;
            end
         endcase
      end
   end

   // program flow: jump load and squash of the already fetched op
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pc_load     <= 1'b0;
         pc_target   <= {PC_W{1'b0}};
         squash_next <= 1'b0;
      end else begin
         pc_load     <= accept && (op_code == relative_jump);
         squash_next <= accept && two_cycle;
         if (accept && (op_code == relative_jump)) begin
            pc_target <= next_pc_target;
         end
      end
   end

   // reference values used only by the checks below
   logic [`MAABE_DATA_W:0]    chk_sum;
   logic [`MAABE_DATA_W:0]    chk_sumc;
   logic [`MAABE_DATA_W-1:0]  chk_asr;
   logic [`MAABE_NIB_W:0]     chk_nib;
   logic [PC_W-1:0]           chk_target;
   logic [`MAABE_DATA_W-1:0]  wr_data;
   always_comb begin
      chk_sum    = {1'b0, acc_data} + {1'b0, file_rdata};
      chk_sumc   = chk_sum + {{`MAABE_DATA_W{1'b0}}, carry_flag};
      chk_nib    = {1'b0, acc_data[3:0]} + {1'b0, file_rdata[3:0]};
      chk_asr    = {file_rdata[7], file_rdata[7:1]};
      chk_target = pc_current + PC_W'(1) + PC_W'($signed(jump_offset));
      wr_data    = acc_we ? acc_wdata : file_wdata;
   end

   AST_DEST_ACC: assert property (@(posedge clock) disable iff (rst)
      accept && is_arith && !dest_sel |=> acc_we && !file_we)
      else $error("accumulator destination not honoured");
   AST_DEST_FILE: assert property (@(posedge clock) disable iff (rst)
      accept && is_arith && dest_sel |=> file_we && !acc_we && file_waddr == $past(file_addr))
      else $error("file destination not honoured");
   AST_ADD_RESULT: assert property (@(posedge clock) disable iff (rst)
      accept && op_code == add_acc_to_file |=> wr_data == $past(chk_sum[7:0])
         && carry_flag == $past(chk_sum[8]) && zero_flag == ($past(chk_sum[7:0]) == 8'h00))
      else $error("add result or flags wrong");
   AST_ADDC_RESULT: assert property (@(posedge clock) disable iff (rst)
      accept && op_code == add_acc_file_with_carry |=> wr_data == $past(chk_sumc[7:0])
         && carry_flag == $past(chk_sumc[8]))
      else $error("add with carry result wrong");
   AST_HALF_CARRY: assert property (@(posedge clock) disable iff (rst)
      accept && op_code == add_acc_to_file |=> half_carry_flag == $past(chk_nib[4]))
      else $error("half carry wrong");
   AST_SHIFT: assert property (@(posedge clock) disable iff (rst)
      accept && op_code == arith_shift_right |=> wr_data == $past(chk_asr)
         && carry_flag == $past(file_rdata[0]) && $stable(half_carry_flag))
      else $error("arithmetic shift wrong");
   AST_BIT_CLEAR: assert property (@(posedge clock) disable iff (rst)
      accept && op_code == clear_bit_op |=> file_we && file_wdata[$past(bit_sel)] == 1'b0
         && $stable(carry_flag) && $stable(zero_flag) && $stable(half_carry_flag))
      else $error("bit clear wrong");
   AST_SKIP: assert property (@(posedge clock) disable iff (rst)
      accept && op_code == skip_if_bit_clear && !alu_bit |=> squash_next && !op_ready
         && $stable(zero_flag) ##1 op_ready)
      else $error("skip not two cycles");
   AST_NO_SKIP: assert property (@(posedge clock) disable iff (rst)
      accept && op_code == skip_if_bit_clear && alu_bit |=> !squash_next && op_ready)
      else $error("skip taken with bit set");
   AST_JUMP: assert property (@(posedge clock) disable iff (rst)
      accept && op_code == relative_jump |=> pc_load && pc_target == $past(chk_target)
         && $stable(carry_flag) && !op_ready ##1 op_ready && !pc_load)
      else $error("relative jump wrong");
   AST_NOP_CYCLE: assert property (@(posedge clock) disable iff (rst)
      state == st_nop |=> !acc_we && !file_we && !pc_load && !squash_next)
      else $error("second cycle not a no-operation");
endmodule : maabe_exec
`default_nettype wire

// ==== testbench/mcu_alu_bit_branch_exec_test.sv ====
// self-checking bench for maabe_exec: ops driven at the rising edge, results checked at the falling edge after the accepting edge
// assumes maabe_pkg and maabe_regs.svh are compiled first; no far-side model, bench drives all ports
`include "maabe_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module mcu_alu_bit_branch_exec_test;
   import maabe_pkg::*;
   localparam int PC_W = `MAABE_PC_W;
   localparam int NW   = 23 + PC_W;
   logic                      clock;
   logic                      rst;
   logic                      op_valid;
   maabe_op_t                 op_code;
   logic                      dest_sel;
   logic [6:0]                file_addr;
   logic [2:0]                bit_sel;
   logic [8:0]                jump_offset;
   logic [7:0]                file_rdata;
   logic [7:0]                acc_data;
   logic [PC_W-1:0]           pc_current;
   logic                      op_ready;
   logic                      acc_we;
   logic [7:0]                acc_wdata;
   logic                      file_we;
   logic [6:0]                file_waddr;
   logic [7:0]                file_wdata;
   logic                      carry_flag;
   logic                      half_carry_flag;
   logic                      zero_flag;
   logic                      pc_load;
   logic [PC_W-1:0]           pc_target;
   logic                      squash_next;
   logic                      pend;
   logic                      mc;
   logic                      mdc;
   logic                      mz;
   logic [NW-1:0]             notes[$];
   logic [NW-1:0]             obs;
   int                        err_total;
   int                        comparisons;
   int                        seed;
   logic [31:0]               rv;

   maabe_exec #(.PC_W(PC_W)) i_dut (.clock(clock), .rst(rst), .op_valid(op_valid), .op_code(op_code),
      .dest_sel(dest_sel), .file_addr(file_addr), .bit_sel(bit_sel), .jump_offset(jump_offset),
      .file_rdata(file_rdata), .acc_data(acc_data), .pc_current(pc_current), .op_ready(op_ready),
      .acc_we(acc_we), .acc_wdata(acc_wdata), .file_we(file_we), .file_waddr(file_waddr),
      .file_wdata(file_wdata), .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
      .zero_flag(zero_flag), .pc_load(pc_load), .pc_target(pc_target), .squash_next(squash_next));

   // data and address fields are zeroed unless their strobe is up, so stale values never matter
   assign obs = {acc_we, file_we, carry_flag, half_carry_flag, zero_flag, pc_load, squash_next, op_ready,
                 acc_we ? acc_wdata : (file_we ? file_wdata : 8'h00), file_we ? file_waddr : 7'h00,
                 pc_load ? pc_target : {PC_W{1'b0}}};

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic check(input string what, input logic [NW-1:0] exp, input logic [NW-1:0] seen);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   // present one op, wait for its accept (refused while op_ready is low), then note the expected result
   task automatic issue(input logic [2:0] op, input logic d, input logic [6:0] a, input logic [2:0] b,
                        input logic [8:0] k, input logic [7:0] f, input logic [7:0] w, input logic [PC_W-1:0] pc);
      logic [8:0]      s;
      logic [4:0]      h;
      logic [7:0]      r;
      logic            aw;
      logic            fw;
      logic            pl;
      logic            sq;
      logic            rd;
      logic [PC_W-1:0] pt;
      int              n;
      op_valid <= 1'b1;
      op_code <= maabe_op_t'(op);
      dest_sel <= d;
      file_addr <= a;
      bit_sel <= b;
      jump_offset <= k;
      file_rdata <= f;
      acc_data <= w;
      pc_current <= pc;
      for (n = 0; n < 4; n++) begin
         @(posedge clock);
         if (op_ready === 1'b1) break;
      end
      if (n == 4) begin
         err_total++;
         complete_run();
      end
      {aw, fw, pl, sq, rd, r, pt} = {5'b00001, 8'h00, {PC_W{1'b0}}};
      case (op)
         3'h1, 3'h2: begin
            s = {1'b0, w} + {1'b0, f} + {8'h00, op[1] & mc};
            h = {1'b0, w[3:0]} + {1'b0, f[3:0]} + {4'h0, op[1] & mc};
            r = s[7:0];
            {mc, mdc, mz} = {s[8], h[4], r == 8'h00};
            {aw, fw} = {~d, d};
         end
         3'h3: begin
            r = {f[7], f[7:1]};
            {mc, mz} = {f[0], r == 8'h00};
            {aw, fw} = {~d, d};
         end
         3'h4: {fw, r} = {1'b1, f & ~(8'h01 << b)};
         3'h5: {sq, rd} = {~f[b], f[b]};
         3'h6: {pl, sq, rd, pt} = {3'b110, pc + {{(PC_W-9){1'b0}}, 9'h001} + {{(PC_W-9){k[8]}}, k}};
         default: r = 8'h00;
      endcase
      notes.push_back({aw, fw, mc, mdc, mz, pl, sq, rd, r, fw ? a : 7'h00, pt});
   endtask : issue

   task automatic idle(input int n);
      op_valid <= 1'b0;
      repeat (n) @(posedge clock);
   endtask : idle

   task automatic test_done(input string name);
      $display("test %s finished, mismatches so far %0d", name, err_total);
   endtask : test_done

   always @(posedge clock or posedge rst) begin
      if (rst) pend <= 1'b0;
      else pend <= op_valid & op_ready;
   end

   always @(negedge clock) begin
      if (pend && notes.size() == 0) check("note queue", {NW{1'b0}}, {{(NW-1){1'b0}}, 1'b1});
      else if (pend) check("outputs", notes.pop_front(), obs);
      else if (!rst) check("idle strobes", 5'b00001, {acc_we, file_we, pc_load, squash_next, op_ready});
   end

   initial begin
      {err_total, comparisons, seed} = {32'd0, 32'd0, 32'ha81be483};
      {rst, op_valid, dest_sel, file_addr, bit_sel, jump_offset} = {3'b100, 7'h00, 3'h0, 9'h000};
      {op_code, file_rdata, acc_data, pc_current, mc, mdc, mz} = {op_none, 16'h0000, {PC_W{1'b0}}, 3'b000};
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      check("reset flags", 3'b000, {carry_flag, half_carry_flag, zero_flag});
      issue(3'h1, 1'b0, 7'h05, 3'h0, 9'h000, 8'h0f, 8'h01, 15'h0000);
      issue(3'h1, 1'b1, 7'h7f, 3'h0, 9'h000, 8'hff, 8'h01, 15'h0000);
      issue(3'h2, 1'b1, 7'h11, 3'h0, 9'h000, 8'h7f, 8'h80, 15'h0000);
      issue(3'h2, 1'b0, 7'h00, 3'h0, 9'h000, 8'h00, 8'h00, 15'h0000);
      issue(3'h2, 1'b0, 7'h00, 3'h0, 9'h000, 8'h00, 8'h00, 15'h0000);
      test_done("add");
      issue(3'h3, 1'b0, 7'h01, 3'h0, 9'h000, 8'h81, 8'h00, 15'h0000);
      issue(3'h3, 1'b1, 7'h02, 3'h0, 9'h000, 8'h01, 8'h00, 15'h0000);
      issue(3'h3, 1'b1, 7'h03, 3'h0, 9'h000, 8'h7e, 8'h00, 15'h0000);
      test_done("shift");
      for (int b = 0; b < 8; b++) begin
         issue(3'h4, b[0], 7'(7'h7f - b), b[2:0], 9'h000, 8'hff, 8'h55, 15'h0000);
         issue(3'h5, 1'b0, 7'h20, b[2:0], 9'h000, 8'h01 << b, 8'h00, 15'h0000);
         issue(3'h5, 1'b0, 7'h21, b[2:0], 9'h000, ~(8'h01 << b), 8'h00, 15'h0000);
         issue(3'h1, 1'b0, 7'h22, b[2:0], 9'h000, 8'h10, 8'h0f, 15'h0000);
      end
      test_done("bit clear and skip");
      issue(3'h6, 1'b0, 7'h00, 3'h0, 9'h100, 8'h00, 8'h00, 15'h0010);
      issue(3'h6, 1'b0, 7'h00, 3'h0, 9'h0ff, 8'h00, 8'h00, 15'h7f00);
      issue(3'h6, 1'b0, 7'h00, 3'h0, 9'h000, 8'h00, 8'h00, 15'h7fff);
      issue(3'h6, 1'b0, 7'h00, 3'h0, 9'h1ff, 8'h00, 8'h00, 15'h0000);
      issue(3'h0, 1'b1, 7'h00, 3'h0, 9'h000, 8'hff, 8'hff, 15'h0000);
      test_done("jump");
      repeat (200) begin
         rv = $random(seed);
         if (rv[31]) idle(1);
         issue(rv[2:0] == 3'h7 ? 3'h0 : rv[2:0], rv[3], rv[10:4], rv[13:11], rv[22:14], $random(seed),
               $random(seed), $random(seed));
      end
      idle(3);
      test_done("random");
      complete_run();
   end
endmodule : mcu_alu_bit_branch_exec_test
`default_nettype wire
